// ===== verilog/scterc_pkg.sv
// scterc_pkg: constants for the key-sector interpreter and recovery timers
// assumes: 40 MHz core clock, AXI4-Lite register access
package scterc_pkg;
    // ********************************************************************
    // clock and timing
    // ********************************************************************
    localparam int unsigned CLK_HZ       = 40000000;
    localparam int unsigned UNIT_MS      = 100;
    localparam int unsigned UNIT_CYCLES  = CLK_HZ / 1000 * UNIT_MS;
    localparam logic [15:0] MIN_LIMIT    = 16'h0041;
    // ********************************************************************
    // key-sector codes
    // ********************************************************************
    localparam logic [15:0] ACT_ERC      = 16'h0003;
    localparam logic [15:0] ACT_FEAT     = 16'h0004;
    localparam logic [15:0] FN_SET       = 16'h0001;
    localparam logic [15:0] FN_GET       = 16'h0002;
    localparam logic [15:0] FN_OPT       = 16'h0003;
    localparam logic [15:0] SEL_READ     = 16'h0001;
    localparam logic [15:0] SEL_WRITE    = 16'h0002;
    localparam logic [15:0] EXT_TIMEOUT  = 16'h0015;
    localparam int unsigned NUM_FEAT     = 2;
    localparam logic [15:0] FEAT_DEFAULT = 16'h0001;
    localparam int unsigned OPT_PERSIST  = 0;
    // ********************************************************************
    // task-file output values
    // ********************************************************************
    localparam logic [7:0]  ST_OK        = 8'h50;
    localparam logic [7:0]  ST_ERR       = 8'h51;
    localparam logic [7:0]  ERR_ABRT     = 8'h04;
    localparam logic [7:0]  ERR_UNC      = 8'h40;
    // ********************************************************************
    // register map (byte addresses)
    // ********************************************************************
    localparam logic [7:0]  A_KEY0  = 8'h00; // action/function
    localparam logic [7:0]  A_KEY1  = 8'h04; // selection|feature / value
    localparam logic [7:0]  A_KEY2  = 8'h08; // option flags, write=issue
    localparam logic [7:0]  A_TF    = 8'h0c; // status,error,secnum,seccnt
    localparam logic [7:0]  A_CMD   = 8'h10; // host command control
    localparam logic [7:0]  A_LIM   = 8'h14; // write limit | read limit
    localparam logic [7:0]  A_EXT   = 8'h18; // extended status code
    localparam logic [7:0]  A_IST   = 8'h1c; // interrupt status
    localparam logic [7:0]  A_IMSK  = 8'h20; // interrupt mask
    localparam logic [7:0]  A_NVF   = 8'h24; // persistent feature states
    // cmd register fields
    localparam int unsigned CMD_START  = 0;
    localparam int unsigned CMD_DONE   = 1;
    localparam int unsigned CMD_WRITE  = 2;
    localparam int unsigned CMD_QUEUED = 3;
    localparam int unsigned CMD_EXEC   = 4;
    localparam int unsigned CMD_STREAM = 5;
    localparam int unsigned CMD_OOO    = 6;
    localparam int unsigned CMD_NCQLOG = 7;
    // interrupt bits
    localparam int unsigned IRQ_KEY  = 0;
    localparam int unsigned IRQ_TOUT = 1;
    localparam int unsigned IRQ_W    = 2;
    typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT, CMD_RUN} scterc_cmd_t;
endpackage : scterc_pkg

// ===== verilog/scterc_timer.sv
// scterc_timer: counts 100 ms units up to a limit and flags expiry
// assumes: run held high while the command is timed, limit nonzero
`timescale 1ns/1ps
module scterc_timer
    import scterc_pkg::*;
#(
    parameter int unsigned UNIT = UNIT_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // control
    input  wire logic        run,
    input  wire logic [15:0] limit,
    // result
    output logic             expired
);
    logic [31:0] tick_q;
    logic [15:0] units_q;

    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            tick_q  <= '0;
            units_q <= '0;
            expired <= 1'b0;
        end else if (!expired && limit != 16'h0000) begin
            if (tick_q == UNIT - 1) begin
                tick_q  <= '0;
                units_q <= units_q + 16'h0001;
                if (units_q + 16'h0001 == limit) expired <= 1'b1;
            end else begin
                tick_q <= tick_q + 32'h1;
            end
        end
    end
endmodule : scterc_timer

// ===== verilog/scterc_ctrl.sv
// scterc_ctrl: recovery-control and feature-control key-sector interpreter
// assumes: AXI4-Lite master, host command status on the cmd register
//
// Contract
// - action 0003h, selection 1 read 2 write
// - set value in 100 ms units
// - limit below 65 aborts the command
// - return limit low/high in count/number
// - non-queued: time until host completion
// - queued in-order: start at execution
// - no timing for streaming or out-of-order
// - limits volatile, reset to zero
// - on expiry stop command, report error
// - read expiry reports uncorrectable
// - write expiry reports aborted
// - expiry loads extended status 0015h
// - next command clears it except log read
// - action 0004h selects feature control
// - functions set, get state, get options
// - option bit 0 set keeps state persistent
// - volatile change, reset restores persistent
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module scterc_ctrl
    import scterc_pkg::*;
#(
    parameter int unsigned UNIT = UNIT_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // axi write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // axi read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // status
    output logic             cmdAbort,
    output logic             irq
);
    // ********************************************************************
    // state
    // ********************************************************************
    logic [15:0] key0Act_q, key0Fn_q, key1Sel_q, key1Val_q, key2Opt_q;
    logic [7:0]  tfStatus_q, tfError_q, tfSecNum_q, tfSecCnt_q;
    logic [15:0] readLim_q, writeLim_q, ext_q;
    logic [15:0] featVol_q [NUM_FEAT];
    logic [15:0] featNv_q  [NUM_FEAT] = '{default: FEAT_DEFAULT};
    logic [15:0] featOpt_q [NUM_FEAT];
    logic [7:0]  cmd_q;
    logic [IRQ_W-1:0] ist_q, imsk_q;
    scterc_cmd_t cmdSt_q;
    logic        awHeld_q, wHeld_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic        expired, timerRun, wrDo, issue, tout;
    logic [15:0] selLim;
    logic        fIdxOk;
    logic [0:0]  fIdx;

    // ********************************************************************
    // axi write channel
    // ********************************************************************
    assign wrDo = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !awHeld_q && !s_axi_awready;
            s_axi_wready  <= !wHeld_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wrDo) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q > A_NVF || awAddr_q[1:0] != 2'h0)
                              ? 2'h2 : 2'h0;
            end else if (s_axi_bready && s_axi_bvalid) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // key sector and host command registers
    // ********************************************************************
    assign issue = wrDo && awAddr_q == A_KEY2;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            key0Act_q <= '0;
            key0Fn_q  <= '0;
            key1Sel_q <= '0;
            key1Val_q <= '0;
            key2Opt_q <= '0;
            cmd_q     <= '0;
            imsk_q    <= '0;
        end else begin
            cmd_q[CMD_START] <= 1'b0;
            cmd_q[CMD_DONE]  <= 1'b0;
            if (wrDo) begin
                unique case (awAddr_q)
                    A_KEY0: begin
                        key0Act_q <= wData_q[15:0];
                        key0Fn_q  <= wData_q[31:16];
                    end
                    A_KEY1: begin
                        key1Sel_q <= wData_q[15:0];
                        key1Val_q <= wData_q[31:16];
                    end
                    A_KEY2: key2Opt_q <= wData_q[15:0];
                    A_CMD:  cmd_q     <= wData_q[7:0];
                    A_IMSK: imsk_q    <= wData_q[IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ********************************************************************
    // key-sector interpreter
    // ********************************************************************
    assign selLim = (key1Sel_q == SEL_WRITE) ? writeLim_q : readLim_q;
    assign fIdxOk = key1Sel_q == 16'h0001 || key1Sel_q == 16'h0002;
    assign fIdx   = key1Sel_q[1];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            readLim_q  <= '0;
            writeLim_q <= '0;
            tfStatus_q <= ST_OK;
            tfError_q  <= '0;
            tfSecNum_q <= '0;
            tfSecCnt_q <= '0;
            for (int i = 0; i < NUM_FEAT; i++) begin
                featVol_q[i] <= featNv_q[i];
                featOpt_q[i] <= '0;
            end
        end else if (issue) begin
            tfStatus_q <= ST_OK;
            tfError_q  <= '0;
            if (key0Act_q == ACT_ERC && key0Fn_q == FN_SET
                && (key1Sel_q == SEL_READ || key1Sel_q == SEL_WRITE)) begin
                if (key1Val_q < MIN_LIMIT) begin
                    tfStatus_q <= ST_ERR;
                    tfError_q  <= ERR_ABRT;
                end else if (key1Sel_q == SEL_READ) begin
                    readLim_q <= key1Val_q;
                end else begin
                    writeLim_q <= key1Val_q;
                end
            end else if (key0Act_q == ACT_ERC && key0Fn_q == FN_GET
                && (key1Sel_q == SEL_READ || key1Sel_q == SEL_WRITE)) begin
                tfSecCnt_q <= selLim[7:0];
                tfSecNum_q <= selLim[15:8];
            end else if (key0Act_q == ACT_FEAT && fIdxOk) begin
                unique case (key0Fn_q)
                    FN_SET: begin
                        featVol_q[fIdx] <= key1Val_q;
                        featOpt_q[fIdx] <= wData_q[15:0];
                    end
                    FN_GET: begin
                        tfSecCnt_q <= featVol_q[fIdx][7:0];
                        tfSecNum_q <= featVol_q[fIdx][15:8];
                    end
                    FN_OPT: begin
                        tfSecCnt_q <= featOpt_q[fIdx][7:0];
                        tfSecNum_q <= featOpt_q[fIdx][15:8];
                    end
                    default: begin
                        tfStatus_q <= ST_ERR;
                        tfError_q  <= ERR_ABRT;
                    end
                endcase
            end else begin
                tfStatus_q <= ST_ERR;
                tfError_q  <= ERR_ABRT;
            end
        end else if (tout) begin
            tfStatus_q <= ST_ERR;
            tfError_q  <= cmd_q[CMD_WRITE] ? ERR_ABRT : ERR_UNC;
            tfSecCnt_q <= EXT_TIMEOUT[7:0];
            tfSecNum_q <= EXT_TIMEOUT[15:8];
        end
    end

    // persistent copies survive reset; option word rides the issuing write
    always_ff @(posedge core_clk) begin
        if (issue && key0Act_q == ACT_FEAT && fIdxOk && key0Fn_q == FN_SET
            && wData_q[OPT_PERSIST]) begin
            featNv_q[fIdx] <= key1Val_q;
        end
    end

    // ********************************************************************
    // host command timing
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmdSt_q <= CMD_IDLE;
        end else begin
            unique case (cmdSt_q)
                CMD_IDLE: begin
                    if (cmd_q[CMD_START] && !cmd_q[CMD_STREAM]
                        && !(cmd_q[CMD_QUEUED] && cmd_q[CMD_OOO])) begin
                        cmdSt_q <= cmd_q[CMD_QUEUED] ? CMD_WAIT : CMD_RUN;
                    end
                end
                CMD_WAIT: begin
                    if (cmd_q[CMD_DONE]) cmdSt_q <= CMD_IDLE;
                    else if (cmd_q[CMD_EXEC]) cmdSt_q <= CMD_RUN;
                end
                CMD_RUN: begin
                    if (cmd_q[CMD_DONE] || expired) begin
                        cmdSt_q <= CMD_IDLE;
                    end
                end
            endcase
        end
    end

    assign timerRun = cmdSt_q == CMD_RUN;
    assign tout     = timerRun && expired && !cmd_q[CMD_DONE];

    scterc_timer #(
        .UNIT (UNIT)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (timerRun),
        .limit    (cmd_q[CMD_WRITE] ? writeLim_q : readLim_q),
        .expired  (expired)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_q    <= '0;
            cmdAbort <= 1'b0;
        end else begin
            cmdAbort <= tout;
            if (tout) begin
                ext_q <= EXT_TIMEOUT;
            end else if (cmd_q[CMD_START] && !cmd_q[CMD_NCQLOG]) begin
                ext_q <= '0;
            end
        end
    end

    // ********************************************************************
    // interrupts
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ist_q <= '0;
            irq   <= 1'b0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if ((i == IRQ_KEY && issue) || (i == IRQ_TOUT && tout)) begin
                    ist_q[i] <= 1'b1;
                end else if (wrDo && awAddr_q == A_IST && wData_q[i]) begin
                    ist_q[i] <= 1'b0;
                end
            end
            irq <= |(ist_q & imsk_q);
        end
    end

    // ********************************************************************
    // axi read channel
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                unique case (s_axi_araddr)
                    A_KEY0: s_axi_rdata <= {key0Fn_q, key0Act_q};
                    A_KEY1: s_axi_rdata <= {key1Val_q, key1Sel_q};
                    A_KEY2: s_axi_rdata <= {16'h0000, key2Opt_q};
                    A_TF:   s_axi_rdata <= {tfStatus_q, tfError_q,
                                            tfSecNum_q, tfSecCnt_q};
                    A_CMD:  s_axi_rdata <= {24'h000000, cmd_q};
                    A_LIM:  s_axi_rdata <= {writeLim_q, readLim_q};
                    A_EXT:  s_axi_rdata <= {16'h0000, ext_q};
                    A_IST:  s_axi_rdata <= {30'h0, ist_q};
                    A_IMSK: s_axi_rdata <= {30'h0, imsk_q};
                    A_NVF:  s_axi_rdata <= {featNv_q[1], featNv_q[0]};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : scterc_ctrl

// ===== sim/scterc_ctrl_properties.sv
// scterc_ctrl_properties: port checker for the key-sector interpreter
// assumes: bound to scterc_ctrl, one clock domain, sync active-high reset
`timescale 1ns/1ps
module scterc_ctrl_checker (
    // clock and reset
    input logic        core_clk,
    input logic        rst,
    // axi handshakes
    input logic        s_axi_awvalid,
    input logic        s_axi_wvalid,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // status
    input logic        cmdAbort,
    input logic        irq
);
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_B_BOUND: assert property (s_axi_awvalid && s_axi_wvalid
        |-> ##[1:4] s_axi_bvalid)
        else $error("no write response");
    AST_R_BOUND: assert property (s_axi_arvalid |-> ##[1:3] s_axi_rvalid)
        else $error("no read data");
    AST_B_CAUSE: assert property ($rose(s_axi_bvalid)
        |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
        else $error("write response without write");
    AST_ABORT_PULSE: assert property (cmdAbort |=> !cmdAbort)
        else $error("abort pulse too long");
    AST_RST_QUIET: assert property ($fell(rst)
        |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active after reset");
    AST_NO_EARLY: assert property ($fell(rst) |-> !cmdAbort [*8])
        else $error("timeout with zero limits");

    // ****************************************************************
    // covers
    // ****************************************************************
    COV_ABORT: cover property (cmdAbort);
    COV_IRQ: cover property (irq);
    COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : scterc_ctrl_checker

bind scterc_ctrl scterc_ctrl_checker chk (.*);

// ===== sim/scterc_host_model.sv
// scterc_host_model: host adapter issuing axi4-lite accesses
// assumes: registered slave outputs, one access of each kind at a time
`timescale 1ns/1ps
module scterc_host_model (
    // clock
    input  logic        core_clk,
    // axi write
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    input  logic [1:0]  s_axi_bresp,
    // axi read
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    output logic [7:0]  s_axi_araddr,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready,
    input  logic [31:0] s_axi_rdata,
    input  logic [1:0]  s_axi_rresp
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
    end

    // handshakes judged on values settled before each rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge core_clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (aw) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (w) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar, v;
        v = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v) begin
            @(negedge core_clk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ar) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : scterc_host_model

// ===== sim/test_sct_recovery_feature_ctrl.sv
// test_sct_recovery_feature_ctrl: key-sector and timer tests
// assumes: host model drives the axi port, unit shortened to 10 cycles
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_sct_recovery_feature_ctrl;
    import scterc_pkg::*;
    localparam logic [31:0] HI = 32'hffff_0000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, cmdAbort, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [47:0] bad [5] = '{{ACT_ERC, FN_SET, 16'h3},
        {ACT_ERC, 16'h4, SEL_READ}, {16'h5, FN_SET, 16'h1},
        {ACT_FEAT, FN_SET, 16'h3}, {ACT_FEAT, 16'h4, 16'h1}};
    int n_fail = 0;
    int n_compared = 0;

    always #12.5 core_clk = ~core_clk;
    scterc_ctrl #(.UNIT(10)) dut (.*);
    scterc_host_model host (.*);

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        host.wr(a, v, rs);
        `CHK(rs, 2'h0)
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] v;
        logic [1:0] rs;
        host.rd(a, v, rs);
        `CHK(v & m, e)
    endtask : rdc
    task automatic key(input logic [15:0] act, fn, w2, w3, opt);
        wr(A_KEY0, {fn, act});
        wr(A_KEY1, {w3, w2});
        wr(A_KEY2, {16'h0, opt});
    endtask : key
    task automatic run(input logic [7:0] c, input logic e);
        logic seen;
        seen = 1'b0;
        wr(A_CMD, {24'h0, c});
        repeat (900) begin
            @(negedge core_clk);
            seen = seen | cmdAbort;
        end
        `CHK(seen, e)
    endtask : run
    task automatic give_verdict;
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic do_reset(input int n);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (n) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        do_reset(12);
        rdc(A_LIM, 32'h0);
        host.rd(8'h40, d, r);
        `CHK({d, r}, 34'h2)
        host.wr(8'h44, 32'h1, r);
        `CHK(r, 2'h2)
        key(ACT_ERC, FN_SET, SEL_READ, 16'd65, 16'h0);
        rdc(A_TF, 32'h5000_0000, HI);
        key(ACT_ERC, FN_SET, SEL_WRITE, 16'd66, 16'h0);
        rdc(A_LIM, 32'h0042_0041);
        key(ACT_ERC, FN_GET, SEL_WRITE, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0042);
        key(ACT_ERC, FN_SET, SEL_READ, 16'd64, 16'h0);
        rdc(A_TF, 32'h5104_0000, HI);
        foreach (bad[i]) begin
            key(bad[i][47:32], bad[i][31:16], bad[i][15:0], 16'd99, 16'h0);
            rdc(A_TF, 32'h5104_0000, HI);
        end
        rdc(A_LIM, 32'h0042_0041);
        key(ACT_FEAT, FN_GET, 16'h1, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0001);
        key(ACT_FEAT, FN_SET, 16'h1, 16'h3, 16'h0);
        key(ACT_FEAT, FN_GET, 16'h1, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0003);
        key(ACT_FEAT, FN_OPT, 16'h1, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0000);
        key(ACT_FEAT, FN_SET, 16'h2, 16'h2, 16'h1);
        rdc(A_NVF, 32'h0002_0001);
        key(ACT_FEAT, FN_OPT, 16'h2, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0001);
        do_reset(3);
        key(ACT_FEAT, FN_GET, 16'h1, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0001);
        key(ACT_FEAT, FN_GET, 16'h2, 16'h0, 16'h0);
        rdc(A_TF, 32'h5000_0002);
        rdc(A_LIM, 32'h0);
        key(ACT_ERC, FN_SET, SEL_READ, 16'd65, 16'h0);
        key(ACT_ERC, FN_SET, SEL_WRITE, 16'd65, 16'h0);
        wr(A_IST, 32'h3);
        wr(A_IMSK, 32'h2);
        run(8'h01, 1'b1);
        rdc(A_TF, 32'h5140_0015);
        rdc(A_EXT, 32'h15);
        @(negedge core_clk);
        `CHK(irq, 1'b1)
        wr(A_IST, 32'h2);
        repeat (3) @(negedge core_clk);
        `CHK(irq, 1'b0)
        wr(A_CMD, 32'h81);
        rdc(A_EXT, 32'h15);
        wr(A_CMD, 32'h02);
        wr(A_CMD, 32'h01);
        rdc(A_EXT, 32'h0);
        wr(A_CMD, 32'h02);
        run(8'h05, 1'b1);
        rdc(A_TF, 32'h5104_0015);
        wr(A_CMD, 32'h01);
        run(8'h02, 1'b0);
        run(8'h09, 1'b0);
        run(8'h18, 1'b1);
        run(8'h21, 1'b0);
        run(8'h59, 1'b0);
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        give_verdict();
    end
endmodule : test_sct_recovery_feature_ctrl
